/* File: hdl/sarc_top.sv */
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// Supply alarm and system reset control
// ************************************************
module sarc_top #(
	parameter int REL_COUNT = sarc_pkg::RELEASE_COUNT,
	parameter int ALT_REL   = sarc_pkg::ALT_COUNT
) (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        reset_cmp_low,
	input  wire logic        alarm_cmp,
	input  wire logic        supply_low,
	input  wire logic        core_overload,
	input  wire logic        flash_overload,
	input  wire logic        backup_reg_error,
	input  wire logic        pll_lock,
	input  wire logic        clk_sup_fail,
	input  wire logic        wdog_wrap,
	input  wire logic        lock_opt_strap,
	input  wire logic        alt_count_strap,
	output logic             reset_pin_o,
	output logic             reset_pin_oe,
	output logic             device_reset_n,
	output logic             monitor_active_o,
	output logic             lock_out_pin,
	output logic             alarm_irq_src,
	output logic             osc_startup_mode,
	output logic             irq
);
	// ************************************************
	// Input filtering
	// ************************************************
	sarc_sync_if #(.W(sarc_pkg::SYNC_W)) sif ();

	assign sif.raw = {clk_sup_fail, pll_lock, backup_reg_error,
		flash_overload, core_overload, supply_low, alarm_cmp,
		reset_cmp_low};

	sarc_sync #(.W(sarc_pkg::SYNC_W)) u_sync (
		.mclk    (mclk),
		.reset_n (reset_n),
		.port    (sif)
	);

	wire logic pin_low  = sif.clean[0];
	wire logic alarm_lv = sif.clean[1];
	wire logic sup_low  = sif.clean[2];
	wire logic core_ov  = sif.clean[3];
	wire logic flash_ov = sif.clean[4];
	wire logic back_err = sif.clean[5];
	wire logic pll_lk   = sif.clean[6];
	wire logic clk_fail = sif.clean[7];

	// ************************************************
	// State
	// ************************************************
	logic        alarm_en;
	logic [1:0]  lock_sel;
	logic        core_err;
	logic        flash_err;
	logic        mon_act;
	logic [4:0]  cause;
	logic        cause_written;
	logic        osc_mode;
	logic [2:0]  irq_stat;
	logic [2:0]  irq_mask;
	logic        req_flag;
	logic [11:0] rel_cnt;
	logic        strap_taken;
	logic        lock_opt;
	logic        alt_opt;
	logic        alarm_prev;
	logic        pin_low_prev;

	// ************************************************
	// Bus decode
	// ************************************************
	// One wait state: request seen, answer in the next cycle
	wire logic bus_req  = avs_read | avs_write;
	wire logic wr_now   = avs_write & ~avs_waitrequest;
	wire logic sel_ana  = avs_address == sarc_pkg::OFS_ANALOG;
	wire logic sel_sup  = avs_address == sarc_pkg::OFS_SUPCTL;
	wire logic sel_cau  = avs_address == sarc_pkg::OFS_CAUSE;
	wire logic sel_sby  = avs_address == sarc_pkg::OFS_STANDBY;
	wire logic sel_ist  = avs_address == sarc_pkg::OFS_IRQSTAT;
	wire logic sel_imk  = avs_address == sarc_pkg::OFS_IRQMASK;
	wire logic wr_ana   = wr_now & sel_ana;
	wire logic wr_sup   = wr_now & sel_sup;
	wire logic wr_cau   = wr_now & sel_cau;
	wire logic wr_sby   = wr_now & sel_sby;
	wire logic wr_ist   = wr_now & sel_ist;
	wire logic wr_imk   = wr_now & sel_imk;
	wire logic [7:0] wd = avs_writedata[7:0];

	// ************************************************
	// Reset sources
	// ************************************************
	// Locked option keeps supervision on whatever software writes
	wire logic sup_on   = lock_opt | mon_act;
	wire logic por_src  = sup_on & (sup_low | core_ov | flash_ov);
	wire logic clk_src  = sup_on & clk_fail;
	wire logic fhr_src  = wr_sup & wd[sarc_pkg::BIT_FHR];
	wire logic any_src  = por_src | clk_src | wdog_wrap | fhr_src;
	wire logic [11:0] cnt_last = alt_opt ?
		12'(ALT_REL - 1) : 12'(REL_COUNT - 1);
	wire logic cnt_done = rel_cnt == cnt_last;
	// External reset: pin falls low while we are not pulling it; the
	// edge keeps the lagging filtered pin from blaming the outside
	wire logic ext_src  = pin_low & ~pin_low_prev & ~req_flag;

	// ************************************************
	// Monitor enable write window
	// ************************************************
	wire logic mon_zero_ok = ~lock_opt & ~cause_written &
		(cause[sarc_pkg::BIT_C_POR] | cause[sarc_pkg::BIT_C_CLM]);
	wire logic next_mon_act = (wr_sup & wd[sarc_pkg::BIT_MON]) ? 1'b1 :
		(wr_sup & mon_zero_ok) ? 1'b0 : mon_act;

	// ************************************************
	// Alarm and interrupt terms
	// ************************************************
	// Alarm only counts while pin is above the reset threshold
	wire logic alarm_live = alarm_en & alarm_lv & ~pin_low;
	wire logic [2:0] irq_evt = {flash_ov, core_ov,
		alarm_live & ~alarm_prev};
	wire logic [2:0] next_irq_stat = irq_evt |
		(irq_stat & ~(wr_ist ? wd[2:0] : 3'h0));
	wire logic lock_mux = (lock_sel == sarc_pkg::SARC_LS_PLL)  ? pll_lk :
		(lock_sel == sarc_pkg::SARC_LS_CORE)  ? core_ov :
		(lock_sel == sarc_pkg::SARC_LS_FLASH) ? flash_ov : back_err;

	// ************************************************
	// Cause flags
	// ************************************************
	// Set wins over a clearing write in the same cycle
	wire logic [4:0] cause_set;
	assign cause_set[sarc_pkg::BIT_C_FHR]  = fhr_src;
	assign cause_set[sarc_pkg::BIT_C_CLM]  = clk_src;
	assign cause_set[sarc_pkg::BIT_C_PIN]  = ext_src;
	assign cause_set[sarc_pkg::BIT_C_POR]  = por_src;
	assign cause_set[sarc_pkg::BIT_C_WDOG] = wdog_wrap;
	wire logic [4:0] cause_keep = wr_cau ? 5'h00 : {cause[4:1],
		cause[sarc_pkg::BIT_C_WDOG] & ~por_src};
	wire logic [4:0] next_cause = cause_set | cause_keep;

	// ************************************************
	// Read mux
	// ************************************************
	wire logic [7:0] rd_ana = {alarm_en, 1'b0, lock_sel, 2'b00,
		flash_err, core_err};
	wire logic [7:0] next_rdata = sel_ana ? rd_ana :
		sel_sup ? {7'h00, mon_act} :
		sel_cau ? {3'h0, cause} :
		sel_sby ? {7'h00, osc_mode} :
		sel_ist ? {5'h00, irq_stat} :
		sel_imk ? {5'h00, irq_mask} : 8'h00;

	// ************************************************
	// Bus handshake
	// ************************************************
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= ~(bus_req & avs_waitrequest);
			if (avs_read & avs_waitrequest) begin
				avs_readdata <= {24'h00_0000, next_rdata};
			end
		end
	end

	// ************************************************
	// Straps, caught once after release
	// ************************************************
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			strap_taken <= 1'b0;
			lock_opt    <= 1'b1;
			alt_opt     <= 1'b0;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			lock_opt    <= lock_opt_strap;
			alt_opt     <= alt_count_strap;
		end
	end

	// ************************************************
	// Analog supply register
	// ************************************************
	// Overload level sets the flag each cycle, so it reads 1 while active
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			alarm_en  <= 1'b0;
			lock_sel  <= 2'b00;
			core_err  <= 1'b0;
			flash_err <= 1'b0;
		end else begin
			if (wr_ana) begin
				alarm_en <= wd[sarc_pkg::BIT_ALARM_EN];
				lock_sel <= wd[sarc_pkg::BIT_LS_LO +: 2];
			end
			core_err  <= core_ov |
				(core_err & ~(wr_ana & wd[sarc_pkg::BIT_CORE_ERR]));
			flash_err <= flash_ov |
				(flash_err & ~(wr_ana & wd[sarc_pkg::BIT_FLASH_ERR]));
		end
	end

	// ************************************************
	// Supervision control and cause register
	// ************************************************
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mon_act       <= sarc_pkg::MON_RST;
			cause         <= sarc_pkg::CAUSE_RST;
			cause_written <= 1'b0;
			osc_mode      <= sarc_pkg::OSC_RST;
			pin_low_prev  <= 1'b0;
		end else begin
			mon_act <= next_mon_act;
			cause   <= next_cause;
			pin_low_prev <= pin_low;
			if (wr_cau) begin
				cause_written <= 1'b1;
			end
			// Mode switch timing is left to software
			if (wr_sby) begin
				osc_mode <= wd[sarc_pkg::BIT_OSC];
			end
		end
	end

	// ************************************************
	// Reset request flag and release timer
	// ************************************************
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			req_flag <= 1'b1;
			rel_cnt  <= 12'h000;
		end else if (any_src) begin
			req_flag <= 1'b1;
			rel_cnt  <= 12'h000;
		end else if (req_flag) begin
			if (cnt_done) begin
				req_flag <= 1'b0;
				rel_cnt  <= 12'h000;
			end else begin
				rel_cnt <= rel_cnt + 12'h001;
			end
		end
	end

	// ************************************************
	// Interrupt registers
	// ************************************************
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			irq_stat   <= 3'h0;
			irq_mask   <= 3'h0;
			alarm_prev <= 1'b0;
		end else begin
			irq_stat   <= next_irq_stat;
			alarm_prev <= alarm_live;
			if (wr_imk) begin
				irq_mask <= wd[2:0];
			end
		end
	end

	// ************************************************
	// Registered outputs
	// ************************************************
	// Pull-down follows the request flag, also held by a live source
	// Own pull-down also holds device reset: the filtered pin lags it
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			reset_pin_o      <= 1'b0;
			reset_pin_oe     <= 1'b1;
			device_reset_n   <= 1'b0;
			monitor_active_o <= sarc_pkg::MON_RST;
			lock_out_pin     <= 1'b0;
			alarm_irq_src    <= 1'b0;
			osc_startup_mode <= sarc_pkg::OSC_RST;
			irq              <= 1'b0;
		end else begin
			reset_pin_o      <= 1'b0;
			reset_pin_oe     <= req_flag | any_src;
			device_reset_n   <= ~pin_low & ~reset_pin_oe;
			monitor_active_o <= sup_on;
			lock_out_pin     <= lock_mux;
			alarm_irq_src    <= alarm_live;
			osc_startup_mode <= osc_mode;
			irq              <= |(next_irq_stat & irq_mask);
		end
	end
endmodule
`default_nettype wire

/* File: hdl/sarc_pkg.sv */
// How it works
// - Core regulator overload resets at once and sets core_reg_error.
// - Flash regulator overload resets at once and sets flash_reg_error.
// - lock_out_select picks PLL lock, core, flash or backup error for lock_out_pin.
// - Regulator error flags read 1 while out of spec; write 1 clears.
// - Alarm reaches interrupt source only while alarm_source_enable (bit 7, reset 0).
// - Alarm interrupt is a level, high while pin sits between thresholds.
// - Device held in reset while reset comparator sees pin low.
// - Watchdog, supply, clock supervision and forced reset drive open-drain pin.
// - Any internal source sets the request flag, which enables the pull-down.
// - After sources go quiet, timer counts 2048 (or option) then releases.
// - Five sticky cause flags collect the sources of system resets until a cause write, or for watchdog_cause a supply reset, clears them.
// - Supply or regulator fault holds pin low; gated by monitor_active if unlocked.
// - Reset selects oscillator start-up drive; clearing osc_drive_mode selects run.
// - Supply supervision gives power-on reset on low supply or overload.
// - Writing forced_hw_reset as 1 drives the reset pin low at once.
// - monitor_active resets to 1; zero accepted only in the allowed window.
// - watchdog_cause set on wrap; cleared by supply reset or cause write.
package sarc_pkg;
	// ************************************************
	// Register byte offsets on the bus
	// ************************************************
	localparam logic [4:0] OFS_ANALOG  = 5'h00;
	localparam logic [4:0] OFS_SUPCTL  = 5'h04;
	localparam logic [4:0] OFS_CAUSE   = 5'h08;
	localparam logic [4:0] OFS_STANDBY = 5'h0C;
	localparam logic [4:0] OFS_IRQSTAT = 5'h10;
	localparam logic [4:0] OFS_IRQMASK = 5'h14;

	// ************************************************
	// Field positions
	// ************************************************
	localparam int BIT_ALARM_EN  = 7;
	localparam int BIT_LS_LO     = 4;
	localparam int BIT_FLASH_ERR = 1;
	localparam int BIT_CORE_ERR  = 0;
	localparam int BIT_FHR       = 7;
	localparam int BIT_MON       = 0;
	localparam int BIT_C_FHR     = 4;
	localparam int BIT_C_CLM     = 3;
	localparam int BIT_C_PIN     = 2;
	localparam int BIT_C_POR     = 1;
	localparam int BIT_C_WDOG    = 0;
	localparam int BIT_OSC       = 0;
	localparam int BIT_I_ALARM   = 0;
	localparam int BIT_I_CORE    = 1;
	localparam int BIT_I_FLASH   = 2;

	// ************************************************
	// Reset values and counts
	// ************************************************
	localparam logic [4:0] CAUSE_RST     = 5'h02;
	localparam logic       MON_RST       = 1'b1;
	localparam logic       OSC_RST       = 1'b1;
	localparam int         RELEASE_COUNT = 2048;
	localparam int         ALT_COUNT     = 512;
	localparam int         SYNC_W        = 8;

	// Lock output selections
	typedef enum logic [1:0] {
		SARC_LS_PLL   = 2'b00,
		SARC_LS_CORE  = 2'b01,
		SARC_LS_FLASH = 2'b10,
		SARC_LS_BACK  = 2'b11
	} sarc_ls_t;
endpackage

/* File: hdl/sarc_sync_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Raw pin levels in, filtered levels out
interface sarc_sync_if #(parameter int W = 8);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport sync (input raw, output clean);
	modport user (output raw, input clean);
endinterface
`default_nettype wire

/* File: hdl/sarc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// Three-stage input filter
// ************************************************
module sarc_sync #(
	parameter int W = 8
) (
	input  wire logic   mclk,
	input  wire logic   reset_n,
	sarc_sync_if.sync   port
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;
	logic [W-1:0] held;

	// Stage 1 feeds stage 2 only; a change counts once 2 and 3 agree
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			held   <= '0;
		end else begin
			stage1 <= port.raw;
			stage2 <= stage1;
			stage3 <= stage2;
			for (int i = 0; i < W; i++) begin
				if (stage2[i] == stage3[i]) begin
					held[i] <= stage3[i];
				end
			end
		end
	end

	assign port.clean = held;
endmodule
`default_nettype wire

/* File: bench/sarc_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Reset pin wire with outside reset sources and supply divider
module sarc_pin_model (
	input  wire logic       pin_oe,
	input  wire logic       ext_low,
	input  wire logic [1:0] level,
	output logic            cmp_low,
	output logic            alarm
);
	logic pin_low;
	// Wired-OR: any puller wins, else divider level 0 below, 1 between
	assign pin_low = pin_oe | ext_low | (level == 2'h0);
	assign cmp_low = pin_low;
	assign alarm   = pin_low | (level == 2'h1);
endmodule
`default_nettype wire

/* File: bench/sarc_top_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// Reset pin and alarm outputs against inputs and bus writes
module sarc_top_checker #(
	parameter int REL_COUNT = 8,
	parameter int ALT_REL   = 4
) (
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic        avs_waitrequest,
	input wire logic        reset_cmp_low,
	input wire logic        alarm_cmp,
	input wire logic        core_overload,
	input wire logic        wdog_wrap,
	input wire logic        alt_count_strap,
	input wire logic        reset_pin_o,
	input wire logic        reset_pin_oe,
	input wire logic        device_reset_n,
	input wire logic        monitor_active_o,
	input wire logic        alarm_irq_src
);
	logic        wr_ok;
	logic        en_sh;
	logic [11:0] hi_cnt;
	assign wr_ok = avs_write & ~avs_waitrequest;
	// Enable shadow follows accepted writes; hi_cnt times the pull-down
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			en_sh  <= 1'h0;
			hi_cnt <= 12'h000;
		end else begin
			if (wr_ok && avs_address == sarc_pkg::OFS_ANALOG)
				en_sh <= avs_writedata[7];
			hi_cnt <= reset_pin_oe ? hi_cnt + 12'h001 : 12'h000;
		end
	end
	// ******
	// Rules
	// ******
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	pin_data_a: assert property (reset_pin_o == 1'h0)
		else $error("pin data not low");
	dev_hold_a: assert property (reset_cmp_low [*7] |-> !device_reset_n)
		else $error("device left reset while pin low");
	fhr_pull_a: assert property (wr_ok && avs_writedata[7]
		&& avs_address == sarc_pkg::OFS_SUPCTL |-> ##[1:2] reset_pin_oe)
		else $error("forced reset not on pin");
	wdog_pull_a: assert property (wdog_wrap |-> ##[1:2] reset_pin_oe)
		else $error("watchdog did not pull pin");
	release_a: assert property ($fell(reset_pin_oe)
		|-> hi_cnt >= (alt_count_strap ? ALT_REL : REL_COUNT))
		else $error("pin released early");
	ovl_pull_a: assert property ((core_overload && monitor_active_o) [*6]
		|-> reset_pin_oe)
		else $error("overload did not pull pin");
	alarm_gate_a: assert property (!en_sh && !$past(en_sh) |-> !alarm_irq_src)
		else $error("alarm source while disabled");
	alarm_lvl_a: assert property ((en_sh && alarm_cmp && !reset_cmp_low) [*8]
		|-> alarm_irq_src)
		else $error("alarm source missing");
endmodule
bind sarc_top sarc_top_checker #(
	.REL_COUNT(REL_COUNT),
	.ALT_REL  (ALT_REL)
) i_chk (.*);
`default_nettype wire

/* File: bench/sarc_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// Compare one value, count it, report a mismatch
`define CHK(n, e, a) begin \
	num_checks++; \
	if ((a) !== (e)) begin \
		err_total++; \
		$display("[FAIL] %s exp %h got %h", n, e, a); \
	end \
end
module sarc_top_tb;
	localparam int REL = 8;
	localparam int ALT = 4;
	logic        mclk = 1'h0, reset_n = 1'h0, avs_read = 1'h0;
	logic        avs_write = 1'h0, avs_waitrequest;
	logic [4:0]  avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, r;
	logic        core_ovl = 1'h0, flash_ovl = 1'h0, backup_err = 1'h0;
	logic        pll_lk = 1'h0, wdog = 1'h0, ext_low = 1'h0;
	logic        sup_low = 1'h0, clk_fail = 1'h0;
	logic        lock_strap = 1'h0, alt_strap = 1'h0;
	logic [1:0]  level = 2'h2;
	logic        cmp_low, alarm, pin_o, pin_oe, dev_rst_n, mon_o;
	logic        lock_o, alarm_src, osc_o, irq;
	logic [7:0]  exp_q[$], e;
	integer      seed = 7;
	int          err_total = 0, num_checks = 0, i;
	always #50 mclk = ~mclk;
	sarc_top #(.REL_COUNT(REL), .ALT_REL(ALT)) i_dut (
		.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .reset_cmp_low(cmp_low),
		.alarm_cmp(alarm), .supply_low(sup_low), .core_overload(core_ovl),
		.flash_overload(flash_ovl), .backup_reg_error(backup_err),
		.pll_lock(pll_lk), .clk_sup_fail(clk_fail), .wdog_wrap(wdog),
		.lock_opt_strap(lock_strap), .alt_count_strap(alt_strap),
		.reset_pin_o(pin_o), .reset_pin_oe(pin_oe),
		.device_reset_n(dev_rst_n), .monitor_active_o(mon_o),
		.lock_out_pin(lock_o), .alarm_irq_src(alarm_src),
		.osc_startup_mode(osc_o), .irq(irq)
	);
	sarc_pin_model i_pin (.pin_oe(pin_oe), .ext_low(ext_low),
		.level(level), .cmp_low(cmp_low), .alarm(alarm));
	// ******
	// Tasks
	// ******
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Request stands until waitrequest is sampled low at a rising edge
	task automatic bus(input bit wr, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		avs_address   <= a;
		avs_writedata <= {24'h0, d};
		avs_write     <= wr;
		avs_read      <= !wr;
		@(posedge mclk);
		while (avs_waitrequest !== 1'h0 && n < 20) begin
			n++;
			@(posedge mclk);
		end
		if (n == 20) begin
			err_total++;
			summarize();
		end
		avs_write <= 1'h0;
		avs_read  <= 1'h0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] x);
		exp_q.push_back(x);
		bus(0, a, 8'h00);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// Pull-down must last about the release count, not much less
	task automatic hold(input string s);
		int n;
		n = 0;
		while (pin_oe !== 1'h0 && n < 200) begin
			@(negedge mclk);
			n++;
		end
		@(posedge mclk);
		`CHK(s, 1'h1, n >= REL - 1 && n <= REL + 8)
		if (n == 200) summarize();
	endtask
	task automatic pulse();
		wdog <= 1'h1;
		@(posedge mclk);
		wdog <= 1'h0;
	endtask
	// Read answers taken at the edge that samples waitrequest low
	always @(posedge mclk) begin
		if (avs_read === 1'h1 && avs_waitrequest === 1'h0) begin
			e = exp_q.pop_front();
			`CHK("readdata", e, avs_readdata[7:0])
		end
	end
	initial begin
		#5000000;
		err_total++;
		summarize();
	end
	// ******
	// Scenarios
	// ******
	initial begin
		cyc(10);
		reset_n <= 1'h1;
		hold("power-on hold");
		cyc(8);
		bus(1, 5'h18, 8'hFF);
		rd(5'h18, 8'h00);
		rd(5'h0C, 8'h01);
		rd(5'h08, 8'h02);
		rd(5'h04, 8'h01);
		rd(5'h00, 8'h00);
		bus(1, 5'h04, 8'h00);
		rd(5'h04, 8'h00);
		`CHK("monitor", 1'h0, mon_o)
		bus(1, 5'h04, 8'h01);
		bus(1, 5'h08, 8'h00);
		bus(1, 5'h04, 8'h00);
		rd(5'h04, 8'h01);
		rd(5'h08, 8'h00);
		bus(1, 5'h04, 8'h81);
		hold("forced hold");
		cyc(8);
		rd(5'h08, 8'h10);
		bus(1, 5'h08, 8'h00);
		pulse();
		cyc(5);
		pulse();
		cyc(2);
		hold("restart");
		cyc(8);
		rd(5'h08, 8'h01);
		bus(1, 5'h10, 8'h07);
		for (i = 0; i < 2; i++) begin
			{flash_ovl, core_ovl} <= 2'(i + 1);
			cyc(10);
			rd(5'h00, 8'(i + 1));
			`CHK("irq masked", 1'h0, irq)
			{flash_ovl, core_ovl} <= 2'h0;
			hold("overload");
			bus(1, 5'h00, 8'(i + 1));
			rd(5'h00, 8'h00);
		end
		bus(1, 5'h14, 8'h06);
		cyc(3);
		`CHK("irq on", 1'h1, irq)
		bus(1, 5'h10, 8'h06);
		cyc(3);
		`CHK("irq off", 1'h0, irq)
		level <= 2'h1;
		cyc(8);
		`CHK("alarm off", 1'h0, alarm_src)
		bus(1, 5'h00, 8'h80);
		cyc(8);
		`CHK("alarm on", 1'h1, alarm_src)
		ext_low <= 1'h1;
		cyc(8);
		`CHK("alarm low", 1'h0, alarm_src)
		`CHK("device reset", 1'h0, dev_rst_n)
		ext_low <= 1'h0;
		level   <= 2'h2;
		cyc(8);
		`CHK("device run", 1'h1, dev_rst_n)
		rd(5'h08, 8'h06);
		for (i = 0; i < 4; i++) begin
			r = $random(seed);
			{backup_err, flash_ovl, core_ovl, pll_lk} <= r[3:0];
			bus(1, 5'h00, 8'(i << 4));
			cyc(8);
			`CHK("lock out", r[i], lock_o)
		end
		{backup_err, flash_ovl, core_ovl, pll_lk} <= 4'h0;
		cyc(8);
		bus(1, 5'h0C, 8'h00);
		rd(5'h0C, 8'h00);
		`CHK("osc mode", 1'h0, osc_o)
		cyc(4);
		// Clock and supply supervision sources, each with its cause
		bus(1, 5'h08, 8'h00);
		clk_fail <= 1'h1;
		cyc(8);
		clk_fail <= 1'h0;
		hold("clock fail");
		cyc(8);
		rd(5'h08, 8'h08);
		sup_low <= 1'h1;
		cyc(8);
		sup_low <= 1'h0;
		hold("supply low");
		cyc(8);
		rd(5'h08, 8'h0A);
		// Second reset with both straps set: short count, locked monitor
		alt_strap  <= 1'h1;
		lock_strap <= 1'h1;
		reset_n    <= 1'h0;
		cyc(3);
		reset_n <= 1'h1;
		cyc(7);
		`CHK("alt release", 1'h0, pin_oe)
		bus(1, 5'h04, 8'h00);
		rd(5'h04, 8'h01);
		`CHK("monitor locked", 1'h1, mon_o)
		cyc(4);
		summarize();
	end
endmodule
`default_nettype wire
